// ===== rtl/oamx_exec.sv
// Purpose: execute or-with-file, move-file, load-literal, store-acc
// Assumes: register file read is combinational on fr_addr_o
// Notes: one instruction per four clocks, phases q1..q4
`include "oamx_regs.svh"
`default_nettype none
// What this block does
// - or-with-file produces the bitwise or of accumulator and file register.
// - or-with-file writes the accumulator when d is 0, the file when d is 1.
// - move-file copies the file to the accumulator (d=0) or back to itself.
// - move-file updates the zero flag from the moved value, either dest.
// - load-literal (11 00xx) places the 8-bit literal in the accumulator.
// - the don't-care bits of load-literal never change how it decodes.
// - store-acc (00 0000 1fffffff) writes the accumulator to the file.
// - every instruction completes in four phases: decode, read, process, write
module oamx_exec (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [13:0] iw_i,
  input wire logic [7:0] fr_rdata_i,
  output logic [6:0] fr_addr_o,
  output logic [7:0] fr_wdata_o,
  output logic fr_we_o,
  output logic [7:0] acc_o,
  output logic zero_o,
  output logic [3:0] phase_o,
  output logic iw_take_o
);
  // ****************************************
  // phase sequencer
  // ****************************************
  oamx_pkg::oamx_phase_e ph_r;
  oamx_pkg::oamx_phase_e ph_nxt;
  always_comb begin
    unique case (ph_r)
      oamx_pkg::OAMX_Q1: ph_nxt = oamx_pkg::OAMX_Q2;
      oamx_pkg::OAMX_Q2: ph_nxt = oamx_pkg::OAMX_Q3;
      oamx_pkg::OAMX_Q3: ph_nxt = oamx_pkg::OAMX_Q4;
      oamx_pkg::OAMX_Q4: ph_nxt = oamx_pkg::OAMX_Q1;
      default: ph_nxt = oamx_pkg::OAMX_Q1;
    endcase
  end
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ph_r <= oamx_pkg::OAMX_Q1;
    end else begin
      ph_r <= ph_nxt;
    end
  end
  wire logic in_q1;
  wire logic in_q2;
  wire logic in_q3;
  wire logic in_q4;
  assign in_q1 = ph_r == oamx_pkg::OAMX_Q1;
  assign in_q2 = ph_r == oamx_pkg::OAMX_Q2;
  assign in_q3 = ph_r == oamx_pkg::OAMX_Q3;
  assign in_q4 = ph_r == oamx_pkg::OAMX_Q4;
  assign phase_o = ph_r;
  assign iw_take_o = in_q1;

  // ****************************************
  // q1: decode and latch the instruction
  // ****************************************
  oamx_pkg::oamx_op_e dec_op;
  logic dec_dest;
  logic [6:0] dec_fa;
  logic [7:0] dec_lit;
  oamx_decode u_dec (
    .iw_i(iw_i),
    .op_o(dec_op),
    .dest_file_o(dec_dest),
    .faddr_o(dec_fa),
    .literal_o(dec_lit)
  );
  oamx_pkg::oamx_op_e op_r;
  logic dest_r;
  logic [6:0] fa_r;
  logic [7:0] opnd_r;
  logic [7:0] res_r;
  logic [7:0] acc_r;
  logic zero_r;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      op_r <= oamx_pkg::OAMX_OP_NONE;
      dest_r <= 1'b0;
      fa_r <= 7'h00;
      opnd_r <= 8'h00;
    end else if (in_q1) begin
      op_r <= dec_op;
      dest_r <= dec_dest;
      fa_r <= dec_fa;
      opnd_r <= dec_lit;
    end else if (in_q2 && op_r != oamx_pkg::OAMX_OP_LOAD_LIT) begin
      // q2 reads the operand: file register, or keep the literal
      opnd_r <= fr_rdata_i;
    end
  end

  // ****************************************
  // q3: process data
  // ****************************************
  wire logic [7:0] ior_val;
  wire logic [7:0] proc_val;
  assign ior_val = acc_r | opnd_r;
  // move-file and literal pass the operand; store passes acc, not its operand
  assign proc_val = (op_r == oamx_pkg::OAMX_OP_IOR) ? ior_val :
                    (op_r == oamx_pkg::OAMX_OP_STORE_ACC) ? acc_r : opnd_r;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      res_r <= 8'h00;
    end else if (in_q3) begin
      res_r <= proc_val;
    end
  end

  // ****************************************
  // q4: write destination and flags
  // ****************************************
  wire logic op_or;
  wire logic op_mv;
  wire logic op_lit;
  wire logic op_st;
  assign op_or = op_r == oamx_pkg::OAMX_OP_IOR;
  assign op_mv = op_r == oamx_pkg::OAMX_OP_MOVE_FILE;
  assign op_lit = op_r == oamx_pkg::OAMX_OP_LOAD_LIT;
  assign op_st = op_r == oamx_pkg::OAMX_OP_STORE_ACC;
  wire logic to_acc;
  wire logic to_file;
  wire logic zero_upd;
  assign to_acc = in_q4 && (((op_or || op_mv) && !dest_r) || op_lit);
  assign to_file = in_q4 && (((op_or || op_mv) && dest_r) || op_st);
  // store and literal never touch zero
  assign zero_upd = in_q4 && (op_or || op_mv);
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_r <= `OAMX_ACC_RST;
      zero_r <= 1'b0;
    end else begin
      if (to_acc) begin
        acc_r <= res_r;
      end
      if (zero_upd) begin
        zero_r <= res_r == 8'h00;
      end
    end
  end
  // file address held for the whole cycle so q2 read and q4 write agree
  assign fr_addr_o = fa_r;
  assign fr_wdata_o = res_r;
  assign fr_we_o = to_file;
  assign acc_o = acc_r;
  assign zero_o = zero_r;
endmodule // oamx_exec
`default_nettype wire

// ===== rtl/oamx_regs.svh
// Purpose: constants for the or/move/literal/store instruction executor
// Assumes: 14-bit instruction words, 7-bit file addresses
// Notes: opcodes are compared against masked instruction bits
`ifndef OAMX_REGS_SVH
`define OAMX_REGS_SVH

`define OAMX_IW_W 14
`define OAMX_FA_W 7
// opcode field [13:8] of the byte-oriented group
`define OAMX_OP_OR_ACC_WITH_FILE 6'h04
`define OAMX_OP_MOVE_FILE_REG 6'h08
`define OAMX_OP_STORE_ACC_TO_FILE 6'h00
// load literal: top bits 11, then 00, then two don't-care bits
`define OAMX_LIT_MASK 14'h3C00
`define OAMX_LIT_CODE 14'h3000
// store: bits [13:7] equal 0000001
`define OAMX_STORE_MASK 14'h3F80
`define OAMX_STORE_CODE 14'h0080
`define OAMX_DEST_BIT 7
`define OAMX_ACC_RST 8'h00

`endif

// ===== rtl/oamx_pkg.sv
// Purpose: types for the instruction executor
// Assumes: nothing beyond the header
// Notes: phase codes are one-hot
`default_nettype none
package oamx_pkg;
  typedef enum logic [3:0] {
    OAMX_Q1 = 4'h1,
    OAMX_Q2 = 4'h2,
    OAMX_Q3 = 4'h4,
    OAMX_Q4 = 4'h8
  } oamx_phase_e;
  typedef enum logic [2:0] {
    OAMX_OP_NONE,
    OAMX_OP_IOR,
    OAMX_OP_MOVE_FILE,
    OAMX_OP_LOAD_LIT,
    OAMX_OP_STORE_ACC
  } oamx_op_e;
endpackage : oamx_pkg
`default_nettype wire

// ===== rtl/oamx_decode.sv
// Purpose: combinational decode of one instruction word
// Assumes: word is stable while decoded
// Notes: unknown words decode to none and change nothing
`include "oamx_regs.svh"
`default_nettype none
module oamx_decode (
  input wire logic [13:0] iw_i,
  output oamx_pkg::oamx_op_e op_o,
  output logic dest_file_o,
  output logic [6:0] faddr_o,
  output logic [7:0] literal_o
);
  wire logic [5:0] opfield;
  wire logic is_lit;
  wire logic is_store;
  wire logic is_ior;
  wire logic is_move_file_reg;
  assign opfield = iw_i[13:8];
  // don't-care bits are masked off, so any value decodes alike
  assign is_lit = (iw_i & `OAMX_LIT_MASK) == `OAMX_LIT_CODE;
  assign is_store = (iw_i & `OAMX_STORE_MASK) == `OAMX_STORE_CODE;
  assign is_ior = opfield == `OAMX_OP_OR_ACC_WITH_FILE;
  assign is_move_file_reg = opfield == `OAMX_OP_MOVE_FILE_REG;
  assign op_o = is_lit ? oamx_pkg::OAMX_OP_LOAD_LIT :
                is_store ? oamx_pkg::OAMX_OP_STORE_ACC :
                is_ior ? oamx_pkg::OAMX_OP_IOR :
                is_move_file_reg ? oamx_pkg::OAMX_OP_MOVE_FILE :
                oamx_pkg::OAMX_OP_NONE;
  assign dest_file_o = iw_i[`OAMX_DEST_BIT];
  assign faddr_o = iw_i[6:0];
  assign literal_o = iw_i[7:0];
endmodule // oamx_decode
`default_nettype wire

// ===== tb/oamx_rfile.sv
// Purpose: register file model on the far side of the executor
// Assumes: combinational read, write on the edge ending q4
// Notes: cells start at their own address so reads are traceable
`default_nettype none
module oamx_rfile (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [6:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem_r [128];
  initial for (int i = 0; i < 128; i++) mem_r[i] = 8'(i);
  assign rdata_o = mem_r[addr_i];
  always @(posedge clk_i) if (we_i) mem_r[addr_i] <= wdata_i;
endmodule // oamx_rfile
`default_nettype wire

// ===== tb/oamx_exec_properties.sv
// Purpose: timing and result checks for the executor
// Assumes: read data is sampled in q2, results land at q4 end
// Notes: all checks measured from the take in q1
`default_nettype none
module oamx_exec_properties (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [13:0] iw_i,
  input wire logic [7:0] fr_rdata_i,
  input wire logic [7:0] fr_wdata_o,
  input wire logic fr_we_o,
  input wire logic [7:0] acc_o,
  input wire logic zero_o,
  input wire logic [3:0] phase_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  wire logic tk = phase_o == 4'h1;
  wire logic is_or = tk && iw_i[13:8] == 6'h04;
  wire logic is_mv = tk && iw_i[13:8] == 6'h08;
  wire logic is_lit = tk && iw_i[13:10] == 4'hC;
  wire logic is_st = tk && iw_i[13:7] == 7'h01;
  sequence s_quad;
    phase_o == 4'h1 ##1 phase_o == 4'h2 ##1
    phase_o == 4'h4 ##1 phase_o == 4'h8;
  endsequence
  property p_quad; tk |-> s_quad; endproperty
  a_quad: assert property (p_quad) else $error("bad phase");
  property p_lit; is_lit |-> ##4 acc_o == $past(iw_i[7:0], 4); endproperty
  a_lit: assert property (p_lit) else $error("bad literal");
  property p_keep;
    is_lit || is_st |-> ##4 zero_o == $past(zero_o, 4);
  endproperty
  a_keep: assert property (p_keep) else $error("zero moved");
  property p_st; is_st |-> ##3 fr_we_o && fr_wdata_o == acc_o; endproperty
  a_st: assert property (p_st) else $error("bad store");
  property p_ora;
    is_or && !iw_i[7] |->
      ##4 acc_o == ($past(acc_o, 4) | $past(fr_rdata_i, 3));
  endproperty
  a_ora: assert property (p_ora) else $error("bad or");
  property p_orz;
    is_or |->
      ##4 zero_o == (($past(acc_o, 4) | $past(fr_rdata_i, 3)) == 8'h00);
  endproperty
  a_orz: assert property (p_orz) else $error("bad or zero");
  property p_mvz;
    is_mv |-> ##4 zero_o == ($past(fr_rdata_i, 3) == 8'h00);
  endproperty
  a_mvz: assert property (p_mvz) else $error("bad move zero");
  property p_mvf;
    is_mv && iw_i[7] |-> ##3 fr_we_o && fr_wdata_o == $past(fr_rdata_i, 2);
  endproperty
  a_mvf: assert property (p_mvf) else $error("bad move back");
endmodule // oamx_exec_properties
bind oamx_exec oamx_exec_properties u_prop (.mclk_i, .arst_n_i, .iw_i,
  .fr_rdata_i, .fr_wdata_o, .fr_we_o, .acc_o, .zero_o, .phase_o);
`default_nettype wire

// ===== tb/tb_or_and_move_instruction_exec.sv
// Purpose: directed tests of the four instructions
// Assumes: one word per four clocks, first word before first edge
// Notes: file cells start at their address
`default_nettype none
module tb_or_and_move_instruction_exec;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_i = 0, arst_n_i = 0;
  logic [13:0] iw_i = 14'h0000;
  wire logic [7:0] rd, wd, acc;
  wire logic [6:0] fa;
  wire logic we, z, tk;
  int error_cnt = 0, n_tests = 0;
  initial forever #2.5 mclk_i = ~mclk_i;
  oamx_exec u_oamx_exec (.mclk_i, .arst_n_i, .iw_i, .fr_rdata_i(rd),
    .fr_addr_o(fa), .fr_wdata_o(wd), .fr_we_o(we), .acc_o(acc),
    .zero_o(z), .phase_o(), .iw_take_o(tk));
  oamx_rfile u_oamx_rfile (.clk_i(mclk_i), .we_i(we), .addr_i(fa),
    .wdata_i(wd), .rdata_o(rd));
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task run(input logic [13:0] w);
    iw_i = w;
    repeat (4) @(posedge mclk_i);
    #1;
    chk("take", tk, 8'h01);
  endtask
  task t_move;
    run(14'h0880);
    chk("zero", z, 8'h01);
    chk("file00", u_oamx_rfile.mem_r[0], 8'h00);
    run(14'h0813);
    chk("acc", acc, 8'h13);
    chk("zero", z, 8'h00);
    run(14'h0880);
    $display("t_move done");
  endtask
  task t_lit_store;
    run(14'h33A5);
    chk("acc", acc, 8'hA5);
    chk("zero", z, 8'h01);
    run(14'h305A);
    chk("acc", acc, 8'h5A);
    run(14'h00FF);
    chk("file7f", u_oamx_rfile.mem_r[127], 8'h5A);
    chk("zero", z, 8'h01);
    $display("t_lit_store done");
  endtask
  task t_or;
    run(14'h0413);
    chk("acc", acc, 8'h5B);
    chk("zero", z, 8'h00);
    run(14'h04A4);
    chk("file24", u_oamx_rfile.mem_r[36], 8'h7F);
    chk("acc", acc, 8'h5B);
    run(14'h3000);
    run(14'h0400);
    chk("zero", z, 8'h01);
    $display("t_or done");
  endtask
  task wrap_up;
    $display("tests %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #5000;
    error_cnt++;
    wrap_up;
  end
  initial begin
    repeat (4) @(posedge mclk_i);
    #1 arst_n_i = 1;
    t_move;
    t_lit_store;
    t_or;
    wrap_up;
  end
endmodule // tb_or_and_move_instruction_exec
`default_nettype wire
